/* File: logic/ufti_core.sv */
/*
 Serial controller core: receive and transmit FIFOs with threshold events,
 two down-counting timers, control character recognition and a six-block
 prioritised interrupt unit behind one interrupt output, on APB.
 Assumes the serial framer outside delivers received bytes as strobes and
 takes transmit bytes with a ready handshake; one clock, pclk.
*/
// The address map and the APB register port were left to the implementer.
// Summary of operation
// - Two separate four-character FIFOs, one receive and one transmit.
// - Receive FIFO event when occupancy rises above its threshold.
// - Transmit FIFO event when occupancy falls below its threshold.
// - Both thresholds independently written by software.
// - Two timers, each baud generator or general timer.
// - Split rates use both timers; otherwise one timer is free.
// - Timer loads on software command, then counts down on clock.
// - General timer expiry flags a maskable timer request.
// - Received bytes compared with standard or user control set.
// - Recognised control character raises its own interrupt source.
// - Recognition mode is programmable by software.
// - Twenty sources grouped into six blocks.
// - Blocks have fixed priority resolved by hardware.
// - All pending unmasked requests drive one interrupt output.
// - Identification register gives top block and its source.
// - Summary register shows every pending unmasked block.
// - Masks per block and per source gate the output.
// - Pending clears on service (auto) or explicit acknowledge (manual).
module ufti_core #(
   parameter int TMR_W = 16
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial machine side (same clock)
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic [4:0] rx_errors,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic [2:0] tx_events,
   // Baud ticks and interrupt
   output logic tx_baud_tick,
   output logic rx_baud_tick,
   output logic irq
);
   import ufti_pkg::*;

   // Standard control characters: ASCII C0 and DEL, EBCDIC C0 and 0xFF
   function automatic logic is_ctl(input logic [1:0] mode, input logic [7:0] c,
                                   input logic [7:0] u0, input logic [7:0] u1);
      case (mode)
         UFTI_CCR_ASCII: is_ctl = (c < 8'h20) || (c == 8'h7F);
         UFTI_CCR_EBCDIC: is_ctl = (c < 8'h40) || (c == 8'hFF);
         UFTI_CCR_USER: is_ctl = (c == u0) || (c == u1);
         default: is_ctl = 1'b0;
      endcase
   endfunction : is_ctl

   // Block of a source index
   function automatic logic [2:0] blk_of(input int s);
      if (s < UFTI_SRC_TXM0) blk_of = 3'h0;
      else if (s < UFTI_SRC_RXM0) blk_of = 3'h1;
      else if (s < UFTI_SRC_RXF0) blk_of = 3'h2;
      else if (s < UFTI_SRC_TXF0) blk_of = 3'h3;
      else if (s < UFTI_SRC_MDM0) blk_of = 3'h4;
      else blk_of = 3'h5;
   endfunction : blk_of

   // FIFOs
   ufti_fifo_if #(.W(8), .AW(3)) rxf ();
   ufti_fifo_if #(.W(8), .AW(3)) txf ();
   ufti_fifo #(.DEPTH(UFTI_FIFO_DEPTH)) u_rxf (.pclk(pclk), .presetn(presetn), .f(rxf.store));
   ufti_fifo #(.DEPTH(UFTI_FIFO_DEPTH)) u_txf (.pclk(pclk), .presetn(presetn), .f(txf.store));

   // Registers
   logic [2:0] rx_thr_q, rx_thr_d, tx_thr_q, tx_thr_d;
   logic [3:0] tcfg_q, tcfg_d;
   logic [TMR_W-1:0] ld_q [2];
   logic [TMR_W-1:0] ld_d [2];
   logic [TMR_W-1:0] cnt_q [2];
   logic [TMR_W-1:0] cnt_d [2];
   logic [1:0] run_q, run_d, bt_q, bt_d;
   logic [1:0] ccr_mode_q, ccr_mode_d;
   logic [15:0] user_q, user_d;
   logic [5:0] bmask_q, bmask_d;
   logic [UFTI_NSRC-1:0] smask_q, smask_d, pend_q, pend_d, ev;
   logic [5:0] blk_pend;
   logic [2:0] top_blk;
   logic [4:0] top_src;
   logic [31:0] rdata_d, prdata_q;
   logic [2:0] rxc_q, txc_q;
   logic wr_en, rd_en, addr_ok;
   logic [1:0] tmr_exp;
   logic ctl_hit;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;  // Zero wait states: answer in the access cycle

   // Last occupancy, for crossing detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxc_q <= 3'h0;
         txc_q <= 3'h0;
      end else begin
         rxc_q <= rxf.count;
         txc_q <= txf.count;
      end
   end

   // FIFO handshakes; a full receive FIFO drops the byte and flags overrun
   always_comb begin
      rxf.push = rx_valid && !rxf.full;
      rxf.wdata = rx_byte;
      rxf.pop = rd_en && paddr == UFTI_RXDATA && !rxf.empty;
      txf.push = wr_en && paddr == UFTI_TXDATA && !txf.full;
      txf.wdata = pwdata[7:0];
      txf.pop = tx_ready && !txf.empty;
   end
   assign tx_valid = !txf.empty;
   assign tx_byte = txf.rdata;

   // Timers: baud mode reloads and ticks, general mode stops at expiry
   always_comb begin
      ld_d = ld_q;
      cnt_d = cnt_q;
      run_d = run_q;
      bt_d = 2'b00;
      tmr_exp = 2'b00;
      for (int t = 0; t < 2; t++) begin
         if (wr_en && paddr == (t == 0 ? UFTI_TMR0LD : UFTI_TMR1LD)) ld_d[t] = pwdata[TMR_W-1:0];
         if (wr_en && paddr == UFTI_TMRCMD && pwdata[t]) begin
            cnt_d[t] = ld_q[t];
            run_d[t] = 1'b1;
         end else if (run_q[t]) begin
            if (cnt_q[t] == '0) begin
               if (tcfg_q[t]) begin
                  cnt_d[t] = ld_q[t];
                  bt_d[t] = 1'b1;
               end else begin
                  run_d[t] = 1'b0;
                  tmr_exp[t] = 1'b1;
               end
            end else begin
               cnt_d[t] = cnt_q[t] - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int t = 0; t < 2; t++) begin
            ld_q[t] <= '0;
            cnt_q[t] <= '0;
         end
         run_q <= 2'b00;
         bt_q <= 2'b00;
      end else begin
         ld_q <= ld_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         bt_q <= bt_d;
      end
   end

   // Split rates: timer 1 drives receive; else timer 0 drives both
   assign tx_baud_tick = bt_q[0];
   assign rx_baud_tick = tcfg_q[UFTI_SPLIT] ? bt_q[1] : bt_q[0];

   assign ctl_hit = rx_valid && is_ctl(ccr_mode_q, rx_byte, user_q[7:0], user_q[15:8]);

   // Source events
   always_comb begin
      ev = '0;
      ev[UFTI_SRC_TMR0] = tmr_exp[0];
      ev[UFTI_SRC_TMR0+1] = tmr_exp[1];
      ev[UFTI_SRC_TXM0+2:UFTI_SRC_TXM0] = tx_events;
      ev[UFTI_SRC_RXM0] = ctl_hit;
      ev[UFTI_SRC_RXM0+4:UFTI_SRC_RXM0+1] = rx_errors[3:0];
      ev[UFTI_SRC_RXF0] = rxf.count > rx_thr_q && rxc_q <= rx_thr_q;
      ev[UFTI_SRC_RXF0+1] = (rx_valid && rxf.full) || rx_errors[4];
      ev[UFTI_SRC_TXF0] = txf.count < tx_thr_q && txc_q >= tx_thr_q;
   end

   // Register writes and pending flags; a new event wins over a clear
   always_comb begin
      rx_thr_d = rx_thr_q;
      tx_thr_d = tx_thr_q;
      tcfg_d = tcfg_q;
      ccr_mode_d = ccr_mode_q;
      user_d = user_q;
      bmask_d = bmask_q;
      smask_d = smask_q;
      pend_d = pend_q;
      if (wr_en) begin
         case (paddr)
            UFTI_FIFOCFG: begin
               rx_thr_d = pwdata[UFTI_RXTHR_LSB+:3];
               tx_thr_d = pwdata[UFTI_TXTHR_LSB+:3];
            end
            UFTI_TMRCFG: tcfg_d = pwdata[3:0];
            UFTI_CCRCFG: ccr_mode_d = pwdata[1:0];
            UFTI_CCRUSER: user_d = pwdata[15:0];
            UFTI_BLKMASK: bmask_d = pwdata[5:0];
            UFTI_SRCMASK: smask_d = pwdata[UFTI_NSRC-1:0];
            UFTI_ACK: if (!tcfg_q[UFTI_AUTOACK]) pend_d = pend_q & ~pwdata[UFTI_NSRC-1:0];
            UFTI_MODEMEV: pend_d = pend_q | {pwdata[6:0], 13'h0000};
            default: ;
         endcase
      end
      // Auto mode: reading the identification register services the top source
      if (rd_en && paddr == UFTI_TOPID && tcfg_q[UFTI_AUTOACK] && top_blk != UFTI_NO_BLOCK)
         pend_d[top_src] = 1'b0;
      pend_d = pend_d | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_thr_q <= UFTI_RXTHR_RST;
         tx_thr_q <= UFTI_TXTHR_RST;
         tcfg_q <= 4'h0;
         ccr_mode_q <= UFTI_CCR_OFF;
         user_q <= 16'h0000;
         bmask_q <= 6'h00;
         smask_q <= '0;
         pend_q <= '0;
      end else begin
         rx_thr_q <= rx_thr_d;
         tx_thr_q <= tx_thr_d;
         tcfg_q <= tcfg_d;
         ccr_mode_q <= ccr_mode_d;
         user_q <= user_d;
         bmask_q <= bmask_d;
         smask_q <= smask_d;
         pend_q <= pend_d;
      end
   end

   // Block pending and priority; mask bit high enables
   always_comb begin
      blk_pend = 6'h00;
      top_blk = UFTI_NO_BLOCK;
      top_src = 5'h00;
      for (int s = 0; s < UFTI_NSRC; s++)
         if (pend_q[s] && smask_q[s]) blk_pend[blk_of(s)] = 1'b1;
      blk_pend = blk_pend & bmask_q;
      // Lowest index wins: timer highest, modem lowest
      for (int s = UFTI_NSRC - 1; s >= 0; s--)
         if (pend_q[s] && smask_q[s] && bmask_q[blk_of(s)]) begin
            top_blk = blk_of(s);
            top_src = 5'(s);
         end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq <= 1'b0;
      else irq <= |blk_pend;
   end

   // Read mux; unmapped offsets answer with an error
   always_comb begin
      rdata_d = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         UFTI_RXDATA: rdata_d[7:0] = rxf.rdata;
         UFTI_TXDATA: rdata_d = 32'h0000_0000;
         UFTI_FIFOCFG: begin
            rdata_d[UFTI_RXTHR_LSB+:3] = rx_thr_q;
            rdata_d[UFTI_TXTHR_LSB+:3] = tx_thr_q;
         end
         UFTI_FIFOSTAT: rdata_d[6:0] = {txf.count, 1'b0, rxf.count};
         UFTI_TMRCFG: rdata_d[3:0] = tcfg_q;
         UFTI_TMR0LD: rdata_d[TMR_W-1:0] = ld_q[0];
         UFTI_TMR1LD: rdata_d[TMR_W-1:0] = ld_q[1];
         UFTI_TMRCMD: rdata_d = 32'h0000_0000;
         UFTI_TMRSTAT: rdata_d[1:0] = run_q;
         UFTI_CCRCFG: rdata_d[1:0] = ccr_mode_q;
         UFTI_CCRUSER: rdata_d[15:0] = user_q;
         UFTI_BLKMASK: rdata_d[5:0] = bmask_q;
         UFTI_SRCMASK: rdata_d[UFTI_NSRC-1:0] = smask_q;
         UFTI_TOPID: rdata_d[12:0] = {top_src, 5'h00, top_blk};
         UFTI_PENDSUM: rdata_d[5:0] = blk_pend;
         UFTI_SRCPEND: rdata_d[UFTI_NSRC-1:0] = pend_q;
         UFTI_ACK, UFTI_MODEMEV: rdata_d = 32'h0000_0000;
         default: addr_ok = 1'b0;
      endcase
   end

   // Read data is captured in setup so it stands from a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h0000_0000;
      else if (psel && !penable) prdata_q <= rdata_d;
   end
   assign prdata = prdata_q;
   assign pslverr = psel && penable && !addr_ok;
endmodule : ufti_core

/* File: logic/ufti_pkg.sv */
/*
 Shared constants of the serial controller core: register byte offsets,
 field positions, reset values, interrupt block codes and recognition modes.
 Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package ufti_pkg;
   // Register byte offsets
   localparam logic [7:0] UFTI_RXDATA = 8'h00;
   localparam logic [7:0] UFTI_TXDATA = 8'h04;
   localparam logic [7:0] UFTI_FIFOCFG = 8'h08;
   localparam logic [7:0] UFTI_FIFOSTAT = 8'h0C;
   localparam logic [7:0] UFTI_TMRCFG = 8'h10;
   localparam logic [7:0] UFTI_TMR0LD = 8'h14;
   localparam logic [7:0] UFTI_TMR1LD = 8'h18;
   localparam logic [7:0] UFTI_TMRCMD = 8'h1C;
   localparam logic [7:0] UFTI_TMRSTAT = 8'h20;
   localparam logic [7:0] UFTI_CCRCFG = 8'h24;
   localparam logic [7:0] UFTI_CCRUSER = 8'h28;
   localparam logic [7:0] UFTI_BLKMASK = 8'h2C;
   localparam logic [7:0] UFTI_SRCMASK = 8'h30;
   localparam logic [7:0] UFTI_TOPID = 8'h34;
   localparam logic [7:0] UFTI_PENDSUM = 8'h38;
   localparam logic [7:0] UFTI_ACK = 8'h3C;
   localparam logic [7:0] UFTI_SRCPEND = 8'h40;
   localparam logic [7:0] UFTI_MODEMEV = 8'h44;

   // Geometry
   localparam int UFTI_FIFO_DEPTH = 4;
   localparam int UFTI_NSRC = 20;
   localparam int UFTI_NBLK = 6;

   // Field positions in FIFOCFG
   localparam int UFTI_RXTHR_LSB = 0;
   localparam int UFTI_TXTHR_LSB = 4;
   localparam logic [2:0] UFTI_RXTHR_RST = 3'h0;
   localparam logic [2:0] UFTI_TXTHR_RST = 3'h1;

   // TMRCFG bits
   localparam int UFTI_T0_BAUD = 0;
   localparam int UFTI_T1_BAUD = 1;
   localparam int UFTI_SPLIT = 2;
   localparam int UFTI_AUTOACK = 3;

   // Source index ranges per block (block 0 is highest priority)
   localparam int UFTI_SRC_TMR0 = 0;   // Timer block: sources 0..1
   localparam int UFTI_SRC_TXM0 = 2;   // Tx machine: 2..4
   localparam int UFTI_SRC_RXM0 = 5;   // Rx machine: 5..9
   localparam int UFTI_SRC_RXF0 = 10;  // Rx FIFO: 10..11
   localparam int UFTI_SRC_TXF0 = 12;  // Tx FIFO: 12
   localparam int UFTI_SRC_MDM0 = 13;  // Modem: 13..19

   // Control character recognition modes
   typedef enum logic [1:0] {
      UFTI_CCR_OFF = 2'b00,
      UFTI_CCR_ASCII = 2'b01,
      UFTI_CCR_EBCDIC = 2'b10,
      UFTI_CCR_USER = 2'b11
   } ufti_ccr_mode_t;

   localparam logic [2:0] UFTI_NO_BLOCK = 3'h7;
endpackage : ufti_pkg

/* File: logic/ufti_fifo_if.sv */
/*
 Carrier between the core and its character FIFO.
 Assumes a single clock domain.
*/
interface ufti_fifo_if #(parameter int W = 8, parameter int AW = 3);
   logic push;
   logic pop;
   logic [W-1:0] wdata;
   logic [W-1:0] rdata;
   logic [AW-1:0] count;
   logic full;
   logic empty;
   modport owner (output push, output pop, output wdata, input rdata, input count, input full, input empty);
   modport store (input push, input pop, input wdata, output rdata, output count, output full, output empty);
endinterface : ufti_fifo_if

/* File: logic/ufti_fifo.sv */
/*
 Small character FIFO with registered read data (head word kept in a flop).
 Assumes pop is only issued when not empty and push only when not full.
*/
module ufti_fifo #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Owner side
   ufti_fifo_if.store f
);
   import ufti_pkg::*;
   localparam int AW = $clog2(DEPTH);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] mem_d [DEPTH];
   logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
   logic [AW:0] cnt_q, cnt_d;
   logic [7:0] head_q, head_d;

   // Pointer and storage update
   always_comb begin
      mem_d = mem_q;
      rd_d = rd_q;
      wr_d = wr_q;
      cnt_d = cnt_q;
      if (f.push && cnt_q != (AW+1)'(DEPTH)) begin
         mem_d[wr_q] = f.wdata;
         wr_d = AW'(wr_q + 1'b1);
      end
      if (f.pop && cnt_q != '0) begin
         rd_d = AW'(rd_q + 1'b1);
      end
      cnt_d = (AW+1)'(cnt_q + (f.push && cnt_q != (AW+1)'(DEPTH)) - (f.pop && cnt_q != '0));
      // Head word from the next state so read data is always the oldest
      head_d = mem_d[rd_d];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
         head_q <= 8'h00;
      end else begin
         mem_q <= mem_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         cnt_q <= cnt_d;
         head_q <= head_d;
      end
   end

   assign f.rdata = head_q;
   assign f.count = cnt_q;
   assign f.full = cnt_q == (AW+1)'(DEPTH);
   assign f.empty = cnt_q == '0;
endmodule : ufti_fifo

/* File: testbench/ufti_core_sva.sv */
/* Port checker for the serial controller core.
   Assumes it is bound to ufti_core and sees one clock, pclk. */
module ufti_core_sva
   import ufti_pkg::*;
#(
   parameter int TMR_W = 16
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Serial side and interrupt
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic irq
);
   logic acc;
   logic mask_seen_q;
   logic mask_seen_d;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase of any transfer
   assign acc = psel && penable;
   // Sources stay shut until software opens one
   always_comb begin
      mask_seen_d = mask_seen_q | (acc & pwrite & (paddr == UFTI_SRCMASK));
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_seen_q <= 1'b0;
      end else begin
         mask_seen_q <= mask_seen_d;
      end
   end
   a_ready_always: assert property (psel |-> pready)
      else $error("pready low in a transfer");
   a_unmapped_err: assert property (acc && paddr > 8'h44 && paddr[1:0] == 2'b00 |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && paddr <= 8'h44 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   a_prdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_tx_push_shows: assert property (acc && pwrite && paddr == UFTI_TXDATA |=> tx_valid)
      else $error("pushed byte not offered");
   a_tx_head_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("head byte changed while stalled");
   a_tx_drop_pop: assert property ($fell(tx_valid) |-> $past(tx_ready))
      else $error("transmit fifo emptied without pop");
   a_irq_masked: assert property (!mask_seen_q |-> !irq)
      else $error("irq while all sources masked");
endmodule : ufti_core_sva

bind ufti_core ufti_core_sva #(.TMR_W(TMR_W)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .irq(irq));

/* File: testbench/ufti_serial_peer.sv */
/* Model of the serial framer beside the core.
   Assumes the core's clock; a byte leaves on tx_valid and tx_ready. */
module ufti_serial_peer (
   // Clock
   input wire logic pclk,
   // Towards the core
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic [4:0] rx_errors,
   output logic tx_ready,
   output logic [2:0] tx_events,
   // From the core
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stall = 1'b0;
   logic [7:0] got [$];
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'hA5;
      rx_errors = 5'h00;
      tx_ready = 1'b0;
      tx_events = 3'h0;
   end
   // Stall holds the transmit side off, so the fifo can fill
   always @(posedge pclk) begin
      if (tx_valid && tx_ready) got.push_back(tx_byte);
      tx_ready <= !stall;
   end
   // Idle data is inverted so a stale byte never looks valid
   task automatic send_rx(input logic [7:0] b);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_byte <= ~b;
   endtask : send_rx
   task automatic pulse_err(input logic [4:0] m);
      @(posedge pclk);
      rx_errors <= m;
      @(posedge pclk);
      rx_errors <= 5'h00;
   endtask : pulse_err
endmodule : ufti_serial_peer

/* File: testbench/ufti_core_tb.sv */
/* Self-checking bench for the serial controller core.
   Assumes the peer model file and the bound checker are compiled first. */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module ufti_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ufti_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, rx_byte, tx_byte, bt, rnd;
   logic [31:0] pwdata, prdata, q;
   logic rx_valid, tx_valid, tx_ready, tx_baud_tick, rx_baud_tick, irq, e;
   logic [4:0] rx_errors;
   logic [2:0] tx_events;
   logic [7:0] b [4];
   logic [7:0] tbl [5] = '{8'h06, 8'h7F, 8'hFF, 8'h5A, 8'h3A};
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   int n, ntx, nrx;
   ufti_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_errors(rx_errors), .tx_valid(tx_valid),
      .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_events(tx_events), .tx_baud_tick(tx_baud_tick),
      .rx_baud_tick(rx_baud_tick), .irq(irq));
   ufti_serial_peer peer (.pclk(pclk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_errors(rx_errors),
      .tx_ready(tx_ready), .tx_events(tx_events), .tx_valid(tx_valid), .tx_byte(tx_byte));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [7:0] next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : next
   function automatic logic [7:0] topid(input int s);
      logic [2:0] k;
      k = s < UFTI_SRC_TXM0 ? 3'h0 : s < UFTI_SRC_RXM0 ? 3'h1 : s < UFTI_SRC_RXF0 ? 3'h2 :
          s < UFTI_SRC_TXF0 ? 3'h3 : s < UFTI_SRC_MDM0 ? 3'h4 : 3'h5;
      return {5'(s), k};
   endfunction : topid
   function automatic logic ccr_hit(input int m, input logic [7:0] c);
      case (m)
         1: return c < 8'h20 || c == 8'h7F;
         2: return c < 8'h40 || c == 8'hFF;
         3: return c == 8'h5A || c == 8'h3A;
         default: return 1'b0;
      endcase
   endfunction : ccr_hit
   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the hang guard ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic tick(input int m);
      repeat (m) @(posedge pclk);
      #1;
   endtask : tick
   task automatic count_ticks();
      ntx = 0;
      nrx = 0;
      repeat (64) begin
         tick(1);
         ntx += int'(tx_baud_tick);
         nrx += int'(rx_baud_tick);
      end
   endtask : count_ticks
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   // Hang guard, well above the length of the sequence
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      rnd = 8'd81;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, UFTI_FIFOCFG, 0); `CHK(q[6:0], {UFTI_TXTHR_RST, 1'b0, UFTI_RXTHR_RST})
      apb(0, UFTI_TOPID, 0); `CHK(q[2:0], UFTI_NO_BLOCK)
      apb(0, 8'h80, 0); `CHK(e, 1'b1)
      apb(0, UFTI_TOPID, 0); `CHK(e, 1'b0)
      apb(1, UFTI_FIFOCFG, 32'h21);
      apb(0, UFTI_FIFOCFG, 0); `CHK(q[6:0], 7'h21)
      apb(1, UFTI_SRCMASK, 32'hFFFFF);
      apb(1, UFTI_BLKMASK, 32'h3F);
      // Two bytes lift the occupancy above a threshold of one
      for (int i = 0; i < 2; i++) begin
         rnd = next(rnd);
         b[i] = rnd;
         peer.send_rx(rnd);
      end
      tick(4); `CHK(irq, 1'b1)
      apb(0, UFTI_PENDSUM, 0); `CHK(q[5:0], 6'h08)
      apb(0, UFTI_TOPID, 0); `CHK({q[12:8], q[2:0]}, topid(UFTI_SRC_RXF0))
      peer.pulse_err(5'h01);
      apb(0, UFTI_TOPID, 0); `CHK({q[12:8], q[2:0]}, topid(6))
      apb(0, UFTI_PENDSUM, 0); `CHK(q[5:0], 6'h0C)
      apb(1, UFTI_ACK, 32'h40);
      apb(0, UFTI_SRCPEND, 0); `CHK(q[10:6], 5'h10)
      apb(1, UFTI_ACK, 32'h400);
      tick(3); `CHK(irq, 1'b0)
      apb(0, UFTI_RXDATA, 0); `CHK(q[7:0], b[0])
      apb(0, UFTI_FIFOSTAT, 0); `CHK(q[2:0], 3'h1)
      apb(0, UFTI_RXDATA, 0); `CHK(q[7:0], b[1])
      // Every recognition mode against fixed and random bytes
      apb(1, UFTI_CCRUSER, 32'h3A5A);
      for (int m = 0; m < 4; m++) begin
         apb(1, UFTI_CCRCFG, m);
         for (int k = 0; k < 6; k++) begin
            rnd = next(rnd);
            bt = k < 5 ? tbl[k] : rnd;
            apb(1, UFTI_ACK, 32'hFFFFF);
            peer.send_rx(bt);
            tick(4);
            apb(0, UFTI_SRCPEND, 0); `CHK(q[5], ccr_hit(m, bt))
            apb(0, UFTI_RXDATA, 0); `CHK(q[7:0], bt)
         end
      end
      apb(1, UFTI_ACK, 32'hFFFFF);
      peer.send_rx(8'h5A);
      tick(4); `CHK(irq, 1'b1)
      apb(1, UFTI_SRCMASK, 32'hFFFDF);
      tick(3); `CHK(irq, 1'b0)
      apb(1, UFTI_SRCMASK, 32'hFFFFF);
      apb(1, UFTI_BLKMASK, 32'h3B);
      tick(3); `CHK(irq, 1'b0)
      apb(1, UFTI_BLKMASK, 32'h3F);
      tick(3); `CHK(irq, 1'b1)
      apb(1, UFTI_TMRCFG, 32'h1 << UFTI_AUTOACK);
      apb(0, UFTI_TOPID, 0); `CHK({q[12:8], q[2:0]}, topid(5))
      apb(0, UFTI_SRCPEND, 0); `CHK(q[5], 1'b0)
      apb(0, UFTI_RXDATA, 0);
      apb(1, UFTI_TMRCFG, 0);
      // Fill the transmit fifo while the framer stalls, then drain it
      peer.stall <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rnd = next(rnd);
         if (i < 4) b[i] = rnd;
         apb(1, UFTI_TXDATA, {24'h0, rnd});
      end
      apb(0, UFTI_FIFOSTAT, 0); `CHK(q[6:4], 3'h4)
      apb(1, UFTI_ACK, 32'hFFFFF);
      peer.stall <= 1'b0;
      n = 0;
      while (tx_valid !== 1'b0 && n < 100) begin
         tick(1);
         n++;
      end
      `CHK(peer.got.size(), 4)
      for (int i = 0; i < 4; i++) `CHK(peer.got[i], b[i])
      apb(0, UFTI_SRCPEND, 0); `CHK(q[12], 1'b1)
      // General timer: load, count down, one expiry
      apb(1, UFTI_TMR0LD, 20);
      apb(1, UFTI_TMRCMD, 1);
      apb(0, UFTI_TMRSTAT, 0); `CHK(q[0], 1'b1)
      apb(0, UFTI_SRCPEND, 0); `CHK(q[0], 1'b0)
      tick(30);
      apb(0, UFTI_SRCPEND, 0); `CHK(q[0], 1'b1)
      apb(0, UFTI_TMRSTAT, 0); `CHK(q[0], 1'b0)
      // Baud ticks: shared rate, then split rates
      apb(1, UFTI_TMRCFG, 32'h1);
      apb(1, UFTI_TMR0LD, 3);
      apb(1, UFTI_TMRCMD, 1);
      count_ticks();
      `CHK(ntx > 0 && ntx == nrx, 1'b1)
      apb(1, UFTI_TMRCFG, 32'h7);
      apb(1, UFTI_TMR1LD, 7);
      apb(1, UFTI_TMRCMD, 3);
      count_ticks();
      `CHK(ntx > 0 && nrx > 0 && ntx != nrx, 1'b1)
      give_verdict();
   end
endmodule : ufti_core_tb
